// File: src/cmsf_top.sv
// Functional notes
// - Flush/wake input acts only in FIFO or bit-bang modes.
// - Falling edge sends buffered data at once as a short packet.
// - Wake-up is never requested while the wake pull-down is on.
// - Reset puts both channels into asynchronous serial mode.
// - Configuration memory then sets each channel's base mode.
// - After enumeration host commands select bit-bang or serial engine.
// - Command 0x40 in parallel FIFO mode selects synchronous FIFO.
// - Synchronous FIFO accepted only when both channels are async FIFO.
// - In synchronous FIFO channel A owns B's buffers; B unavailable.
// - Unused channel B pins stay at their default idle levels.
// - Config sets memory-capable modes; commands set the others.
// - Command 1 selects async bit-bang, 4 selects sync bit-bang.
`include "cmsf_cfg.svh"

module cmsf_top #(
   parameter int WAKE_CYC = `CMSF_WAKE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic flush_wake_n,
   input wire logic wake_pulldown_en,
   input wire logic suspended,
   input wire logic cfg_valid,
   input wire logic [2:0] cfg_mode_a,
   input wire logic [2:0] cfg_mode_b,
   input wire logic enum_done,
   input wire logic cmd_valid,
   input wire logic cmd_chan,
   input wire logic [7:0] cmd_value,
   input wire logic chb_data_moved,
   output cmsf_pkg::cmsf_mode_t mode_a,
   output cmsf_pkg::cmsf_mode_t mode_b,
   output logic cfg_done,
   output logic cmd_ack,
   output logic cmd_nak,
   output logic chan_b_avail,
   output logic send_now,
   output logic wake_req,
   output logic chb_override,
   output logic chb_data_oe,
   output logic chb_pullup_en,
   output logic chb_tx_space_avail_n,
   output logic chb_rx_data_avail_n,
   output logic chb_strobe_in
);
   cmsf_fw_if fw();

   cmsf_pkg::cmsf_mode_t base_a, base_b;
   cmsf_pkg::cmsf_mode_t next_mode_a, next_mode_b;
   cmsf_pkg::cmsf_mode_t next_base_a, next_base_b;
   logic next_cfg_done, next_ack, next_nak;
   logic b_used, next_b_used;

   // ==========================================================
   // Helpers
   function automatic cmsf_pkg::cmsf_mode_t cfg_to_mode(
         input logic [2:0] code);
      case (code)
         `CMSF_CFG_ASYNC_FIFO: cfg_to_mode = cmsf_pkg::ASYNC_FIFO;
         `CMSF_CFG_SYNC_FIFO: cfg_to_mode = cmsf_pkg::SYNC_FIFO;
         `CMSF_CFG_FAST_SERIAL: cfg_to_mode = cmsf_pkg::FAST_SERIAL;
         `CMSF_CFG_CPU_FIFO: cfg_to_mode = cmsf_pkg::CPU_FIFO;
         default: cfg_to_mode = cmsf_pkg::ASYNC_SERIAL;
      endcase
   endfunction

   function automatic logic fw_capable(input cmsf_pkg::cmsf_mode_t m);
      fw_capable = (m == cmsf_pkg::ASYNC_FIFO) ||
                   (m == cmsf_pkg::SYNC_FIFO) ||
                   (m == cmsf_pkg::CPU_FIFO) ||
                   (m == cmsf_pkg::ASYNC_BB) ||
                   (m == cmsf_pkg::SYNC_BB);
   endfunction

   // ==========================================================
   // Mode state
   always_comb begin
      cmsf_pkg::cmsf_mode_t cfg_a;
      cfg_a = cfg_to_mode(cfg_mode_a);
      next_mode_a = mode_a;
      next_mode_b = mode_b;
      next_base_a = base_a;
      next_base_b = base_b;
      next_cfg_done = cfg_done;
      next_ack = 1'b0;
      next_nak = 1'b0;
      if (!cfg_done && cfg_valid) begin
         // Sync FIFO from memory still needs B in async FIFO
         if (cfg_a == cmsf_pkg::SYNC_FIFO &&
             cfg_to_mode(cfg_mode_b) != cmsf_pkg::ASYNC_FIFO) begin
            cfg_a = cmsf_pkg::ASYNC_FIFO;
         end
         next_mode_a = cfg_a;
         next_mode_b = cfg_to_mode(cfg_mode_b);
         if (next_mode_b == cmsf_pkg::SYNC_FIFO) begin
            next_mode_b = cmsf_pkg::ASYNC_FIFO;
         end
         next_base_a = cfg_a == cmsf_pkg::SYNC_FIFO ?
                       cmsf_pkg::ASYNC_FIFO : cfg_a;
         next_base_b = next_mode_b;
         next_cfg_done = 1'b1;
      end else if (cmd_valid) begin
         next_nak = 1'b1;
         if (cfg_done && enum_done) begin
            case (cmd_value)
               `CMSF_CMD_SYNC_FIFO: begin
                  if (!cmd_chan && mode_a == cmsf_pkg::ASYNC_FIFO &&
                      mode_b == cmsf_pkg::ASYNC_FIFO) begin
                     next_mode_a = cmsf_pkg::SYNC_FIFO;
                     next_nak = 1'b0;
                  end
               end
               `CMSF_CMD_BASE: begin
                  if (!cmd_chan) begin
                     next_mode_a = base_a;
                     next_nak = 1'b0;
                  end else if (mode_a != cmsf_pkg::SYNC_FIFO) begin
                     next_mode_b = base_b;
                     next_nak = 1'b0;
                  end
               end
               `CMSF_CMD_ASYNC_BB, `CMSF_CMD_SYNC_BB,
               `CMSF_CMD_SERIAL_ENG, `CMSF_CMD_HOST_BUS: begin
                  cmsf_pkg::cmsf_mode_t m;
                  m = cmsf_pkg::HOST_BUS;
                  case (cmd_value)
                     `CMSF_CMD_ASYNC_BB: m = cmsf_pkg::ASYNC_BB;
                     `CMSF_CMD_SYNC_BB: m = cmsf_pkg::SYNC_BB;
                     `CMSF_CMD_SERIAL_ENG: m = cmsf_pkg::SERIAL_ENGINE;
                     default: m = cmsf_pkg::HOST_BUS;
                  endcase
                  if (!cmd_chan) begin
                     next_mode_a = m;
                     next_nak = 1'b0;
                  end else if (mode_a != cmsf_pkg::SYNC_FIFO) begin
                     next_mode_b = m;
                     next_nak = 1'b0;
                  end
               end
               default: next_nak = 1'b1;
            endcase
         end
         next_ack = !next_nak;
      end
   end

   // Reset state is serial on both channels
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_a <= cmsf_pkg::ASYNC_SERIAL;
         mode_b <= cmsf_pkg::ASYNC_SERIAL;
         base_a <= cmsf_pkg::ASYNC_SERIAL;
         base_b <= cmsf_pkg::ASYNC_SERIAL;
         cfg_done <= 1'b0;
         cmd_ack <= 1'b0;
         cmd_nak <= 1'b0;
      end else begin
         mode_a <= next_mode_a;
         mode_b <= next_mode_b;
         base_a <= next_base_a;
         base_b <= next_base_b;
         cfg_done <= next_cfg_done;
         cmd_ack <= next_ack;
         cmd_nak <= next_nak;
      end
   end

   // ==========================================================
   // Flush / wake
   assign fw.fw_n = flush_wake_n;
   assign fw.enable = fw_capable(mode_a);
   assign fw.wake_ok = suspended && !wake_pulldown_en;

   cmsf_pulse_meas #(.WAKE_CYC(WAKE_CYC)) u_meas (
      .clk_sys(clk_sys),
      .rst(rst),
      .fw(fw.meas)
   );

   // ==========================================================
   // Channel B pins
   logic next_override, next_oe, next_pu, next_txn, next_rxn, next_stb;
   logic next_b_avail;

   always_comb begin
      next_b_used = b_used;
      if (chb_data_moved && mode_a != cmsf_pkg::SYNC_FIFO) begin
         next_b_used = 1'b1;
      end
      next_b_avail = mode_a != cmsf_pkg::SYNC_FIFO;
      next_override = !next_b_avail;
      // In synchronous FIFO a used channel B keeps whatever it last drove
      next_oe = chb_data_oe;
      next_pu = chb_pullup_en;
      next_txn = chb_tx_space_avail_n;
      next_rxn = chb_rx_data_avail_n;
      next_stb = chb_strobe_in;
      if (next_b_avail || !b_used) begin
         next_oe = `CMSF_CHB_DATA_OE;
         next_pu = `CMSF_CHB_PULLUP;
         next_txn = `CMSF_CHB_TX_SPACE_N;
         next_rxn = `CMSF_CHB_RX_DATA_N;
         next_stb = `CMSF_CHB_STROBE_IN;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         b_used <= 1'b0;
         chan_b_avail <= 1'b1;
         chb_override <= 1'b0;
         chb_data_oe <= `CMSF_CHB_DATA_OE;
         chb_pullup_en <= `CMSF_CHB_PULLUP;
         chb_tx_space_avail_n <= `CMSF_CHB_TX_SPACE_N;
         chb_rx_data_avail_n <= `CMSF_CHB_RX_DATA_N;
         chb_strobe_in <= `CMSF_CHB_STROBE_IN;
         send_now <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         b_used <= next_b_used;
         chan_b_avail <= next_b_avail;
         chb_override <= next_override;
         chb_data_oe <= next_oe;
         chb_pullup_en <= next_pu;
         chb_tx_space_avail_n <= next_txn;
         chb_rx_data_avail_n <= next_rxn;
         chb_strobe_in <= next_stb;
         send_now <= fw.flush;
         wake_req <= fw.wake;
      end
   end

   // ==========================================================
   // Checks
   a_reset_serial_modes: assert property (
      @(posedge clk_sys) disable iff (rst)
      !cfg_done |-> mode_a == cmsf_pkg::ASYNC_SERIAL &&
                    mode_b == cmsf_pkg::ASYNC_SERIAL)
      else $error("mode left serial before configuration");
   a_cfg_base_mode: assert property (
      @(posedge clk_sys) disable iff (rst)
      !cfg_done && cfg_valid &&
      cfg_mode_a == `CMSF_CFG_FAST_SERIAL
      |=> mode_a == cmsf_pkg::FAST_SERIAL && cfg_done)
      else $error("base mode not taken from configuration");
   a_sync_fifo_gate: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(mode_a == cmsf_pkg::SYNC_FIFO) && $past(cfg_done) |->
      $past(mode_a) == cmsf_pkg::ASYNC_FIFO &&
      $past(mode_b) == cmsf_pkg::ASYNC_FIFO &&
      $past(cmd_value) == `CMSF_CMD_SYNC_FIFO)
      else $error("sync FIFO entered from wrong state");
   a_async_bb_code: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfg_done && enum_done && cmd_valid && !cmd_chan &&
      cmd_value == `CMSF_CMD_ASYNC_BB
      |=> mode_a == cmsf_pkg::ASYNC_BB && cmd_ack && !cmd_nak)
      else $error("value 1 did not select async bit-bang");
   a_sync_bb_code: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfg_done && enum_done && cmd_valid && cmd_chan &&
      mode_a != cmsf_pkg::SYNC_FIFO && cmd_value == `CMSF_CMD_SYNC_BB
      |=> mode_b == cmsf_pkg::SYNC_BB)
      else $error("value 4 did not select sync bit-bang");
   a_mode_hold_idle: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfg_done && !cmd_valid |=> $stable(mode_a) && $stable(mode_b))
      else $error("mode changed without a command");
   a_no_cmd_before_enum: assert property (
      @(posedge clk_sys) disable iff (rst)
      cmd_valid && !enum_done && cfg_done |=> cmd_nak && !cmd_ack)
      else $error("command taken before enumeration");
   a_flush_gated_mode: assert property (
      @(posedge clk_sys) disable iff (rst)
      send_now |-> $past(fw_capable(mode_a), 2))
      else $error("flush in a mode without flush support");
   a_wake_pulldown: assert property (
      @(posedge clk_sys) disable iff (rst)
      wake_req |-> !$past(wake_pulldown_en, 2))
      else $error("wake requested with pull-down on");
   a_chb_default_pins: assert property (
      @(posedge clk_sys) disable iff (rst)
      mode_a == cmsf_pkg::SYNC_FIFO && !b_used
      |=> !chan_b_avail && chb_override && !chb_data_oe &&
          chb_pullup_en && !chb_tx_space_avail_n && chb_rx_data_avail_n)
      else $error("channel B pins left default state");
endmodule // cmsf_top

// File: src/cmsf_cfg.svh
`ifndef CMSF_CFG_SVH
`define CMSF_CFG_SVH

// ==========================================================
// Timing
`define CMSF_CLK_MHZ 25
`define CMSF_FLUSH_NS 250
`define CMSF_WAKE_MS 20
`define CMSF_FLUSH_CYC ((`CMSF_FLUSH_NS * `CMSF_CLK_MHZ + 999) / 1000)
`define CMSF_WAKE_CYC (`CMSF_WAKE_MS * 1000 * `CMSF_CLK_MHZ)

// ==========================================================
// Mode switch command values
`define CMSF_CMD_BASE 8'h00
`define CMSF_CMD_ASYNC_BB 8'h01
`define CMSF_CMD_SERIAL_ENG 8'h02
`define CMSF_CMD_SYNC_BB 8'h04
`define CMSF_CMD_HOST_BUS 8'h08
`define CMSF_CMD_SYNC_FIFO 8'h40

// ==========================================================
// Configuration memory base mode codes
`define CMSF_CFG_ASYNC_SERIAL 3'h0
`define CMSF_CFG_ASYNC_FIFO 3'h1
`define CMSF_CFG_SYNC_FIFO 3'h2
`define CMSF_CFG_FAST_SERIAL 3'h3
`define CMSF_CFG_CPU_FIFO 3'h4

// ==========================================================
// Channel B idle pin levels
`define CMSF_CHB_DATA_OE 1'b0
`define CMSF_CHB_PULLUP 1'b1
`define CMSF_CHB_TX_SPACE_N 1'b0
`define CMSF_CHB_RX_DATA_N 1'b1
`define CMSF_CHB_STROBE_IN 1'b1

`endif

// File: src/cmsf_pkg.sv
package cmsf_pkg;
   typedef enum logic [3:0] {
      ASYNC_SERIAL,
      ASYNC_FIFO,
      SYNC_FIFO,
      CPU_FIFO,
      FAST_SERIAL,
      ASYNC_BB,
      SYNC_BB,
      SERIAL_ENGINE,
      HOST_BUS
   } cmsf_mode_t;
endpackage

// File: src/cmsf_fw_if.sv
interface cmsf_fw_if;
   logic fw_n;
   logic enable;
   logic wake_ok;
   logic flush;
   logic wake;
   modport meas(input fw_n, input enable, input wake_ok,
                output flush, output wake);
   modport ctrl(output fw_n, output enable, output wake_ok,
                input flush, input wake);
endinterface

// File: src/cmsf_pulse_meas.sv
`include "cmsf_cfg.svh"

module cmsf_pulse_meas #(
   parameter int WAKE_CYC = `CMSF_WAKE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   cmsf_fw_if.meas fw
);
   localparam int CW = $clog2(WAKE_CYC + 1);

   if (WAKE_CYC < 2) begin : g_bad_wake
      $error("cmsf_pulse_meas: WAKE_CYC too small");
   end

   logic prev;
   logic [CW-1:0] cnt;
   logic flush;
   logic wake;
   logic next_prev;
   logic [CW-1:0] next_cnt;
   logic next_flush;
   logic next_wake;

   // ==========================================================
   // Edge and low-time measurement
   always_comb begin
      next_prev = fw.fw_n;
      next_cnt = cnt;
      next_flush = 1'b0;
      next_wake = 1'b0;
      if (!fw.enable || fw.fw_n) begin
         next_cnt = '0;
      end else if (cnt != CW'(WAKE_CYC)) begin
         next_cnt = cnt + CW'(1);
      end
      // Flush fires on the edge, not on pulse end: no latency wait
      if (fw.enable && prev && !fw.fw_n) begin
         next_flush = 1'b1;
      end
      // Wake fires once per long pulse; counter saturates after
      if (fw.enable && !fw.fw_n && cnt == CW'(WAKE_CYC - 1)) begin
         next_wake = fw.wake_ok;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev <= 1'b1;
         cnt <= '0;
         flush <= 1'b0;
         wake <= 1'b0;
      end else begin
         prev <= next_prev;
         cnt <= next_cnt;
         flush <= next_flush;
         wake <= next_wake;
      end
   end

   assign fw.flush = flush;
   assign fw.wake = wake;

   // ==========================================================
   // Checks
   a_flush_edge_only: assert property (
      @(posedge clk_sys) disable iff (rst)
      flush |-> $past(fw.enable) && $past(prev) && !$past(fw.fw_n))
      else $error("flush without a falling edge");
   a_wake_after_low: assert property (
      @(posedge clk_sys) disable iff (rst)
      wake |-> $past(cnt) == CW'(WAKE_CYC - 1) && !$past(fw.fw_n))
      else $error("wake before full low time");
endmodule // cmsf_pulse_meas

// File: sim/cmsf_fw_driver.sv
// ==========================================================
// External logic that pulses the flush/wake pin low
module cmsf_fw_driver (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [31:0] low_cyc,
   output logic flush_wake_n,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;

   // Caller asks for a pulse only once its data writes have stopped
   // Low time in cycles: 7 for a 250 ns flush, WAKE_CYC+ for wake
   initial begin
      flush_wake_n = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge clk_sys);
         if (go === 1'b1 && !busy) begin
            #1;
            busy = 1'b1;
            flush_wake_n = 1'b0;
            repeat (low_cyc) @(posedge clk_sys);
            #1;
            flush_wake_n = 1'b1;
            busy = 1'b0;
         end
      end
   end
endmodule // cmsf_fw_driver

// File: sim/cmsf_top_tb_top.sv
module cmsf_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int WAKE = 20;
   logic clk_sys = 1'b0, rst = 1'b1, flush_wake_n, wake_pulldown_en = 1'b0;
   logic suspended = 1'b0, cfg_valid = 1'b0, enum_done = 1'b0;
   logic [2:0] cfg_mode_a = 3'h0, cfg_mode_b = 3'h0;
   logic cmd_valid = 1'b0, cmd_chan = 1'b0, chb_data_moved = 1'b0;
   logic [7:0] cmd_value = 8'h00;
   cmsf_pkg::cmsf_mode_t mode_a, mode_b;
   logic cfg_done, cmd_ack, cmd_nak, chan_b_avail, send_now, wake_req;
   logic chb_override, chb_data_oe, chb_pullup_en, chb_tx_space_avail_n;
   logic chb_rx_data_avail_n, chb_strobe_in, go = 1'b0, busy;
   logic [31:0] low_cyc = 32'h0;
   int error_cnt = 0, checks_done = 0, n_send = 0, n_wake = 0;
   logic [7:0] cmd_tab [4] = '{8'h01, 8'h04, 8'h02, 8'h08};
   cmsf_pkg::cmsf_mode_t mode_tab [4] = '{cmsf_pkg::ASYNC_BB,
      cmsf_pkg::SYNC_BB, cmsf_pkg::SERIAL_ENGINE, cmsf_pkg::HOST_BUS};
   int send_tab [4] = '{1, 1, 0, 0};

   always #20 clk_sys = ~clk_sys;

   cmsf_top #(.WAKE_CYC(WAKE)) dut (.clk_sys(clk_sys), .rst(rst),
      .flush_wake_n(flush_wake_n), .wake_pulldown_en(wake_pulldown_en),
      .suspended(suspended), .cfg_valid(cfg_valid),
      .cfg_mode_a(cfg_mode_a), .cfg_mode_b(cfg_mode_b),
      .enum_done(enum_done), .cmd_valid(cmd_valid), .cmd_chan(cmd_chan),
      .cmd_value(cmd_value), .chb_data_moved(chb_data_moved),
      .mode_a(mode_a), .mode_b(mode_b), .cfg_done(cfg_done),
      .cmd_ack(cmd_ack), .cmd_nak(cmd_nak), .chan_b_avail(chan_b_avail),
      .send_now(send_now), .wake_req(wake_req),
      .chb_override(chb_override), .chb_data_oe(chb_data_oe),
      .chb_pullup_en(chb_pullup_en),
      .chb_tx_space_avail_n(chb_tx_space_avail_n),
      .chb_rx_data_avail_n(chb_rx_data_avail_n),
      .chb_strobe_in(chb_strobe_in));

   cmsf_fw_driver ext (.clk_sys(clk_sys), .go(go), .low_cyc(low_cyc),
      .flush_wake_n(flush_wake_n), .busy(busy));

   // Sampled mid-cycle, away from the edge that launches the pulse
   always @(negedge clk_sys) begin
      if (send_now === 1'b1) n_send++;
      if (wake_req === 1'b1) n_wake++;
   end

   // ==========================================================
   // Checking and closing
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hung();
      error_cnt++;
      $display("[FAIL] t=%0t wait ran out", $time);
      give_verdict();
   endtask

   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask

   initial begin
      #2ms;
      hung();
   end

   // ==========================================================
   // Access tasks
   task automatic do_rst();
      rst = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      rst = 1'b0;
   endtask

   task automatic cfg(input logic [2:0] a, input logic [2:0] b);
      int i;
      tick();
      cfg_valid = 1'b1;
      cfg_mode_a = a;
      cfg_mode_b = b;
      tick();
      cfg_valid = 1'b0;
      i = 0;
      while (cfg_done !== 1'b1 && i < 4) begin
         tick();
         i++;
      end
      if (i >= 4) hung();
   endtask

   task automatic cmd(input logic ch, input logic [7:0] v, input logic ea);
      int i;
      tick();
      cmd_valid = 1'b1;
      cmd_chan = ch;
      cmd_value = v;
      tick();
      cmd_valid = 1'b0;
      i = 0;
      while (cmd_ack !== 1'b1 && cmd_nak !== 1'b1 && i < 3) begin
         tick();
         i++;
      end
      chk(cmd_ack, ea);
      chk(cmd_nak, !ea);
   endtask

   task automatic pulse(input int len, input int es, input int ew);
      int i;
      int s0;
      int w0;
      s0 = n_send;
      w0 = n_wake;
      low_cyc = len;
      go = 1'b1;
      i = 0;
      while (busy !== 1'b1 && i < 5) begin
         tick();
         i++;
      end
      go = 1'b0;
      if (busy !== 1'b1) hung();
      while (busy === 1'b1 && i < 200) begin
         tick();
         i++;
      end
      if (i >= 200) hung();
      repeat (5) tick();
      chk(n_send - s0, es);
      chk(n_wake - w0, ew);
   endtask

   // ==========================================================
   // Tests
   initial begin
      do_rst();
      chk(mode_a, cmsf_pkg::ASYNC_SERIAL);
      chk(mode_b, cmsf_pkg::ASYNC_SERIAL);
      chk({chan_b_avail, chb_override}, 2'b10);
      chk({chb_data_oe, chb_pullup_en, chb_tx_space_avail_n}, 3'b010);
      chk({chb_rx_data_avail_n, chb_strobe_in}, 2'b11);
      pulse(7, 0, 0);
      $display("done: reset");

      cfg(3'h1, 3'h1);
      chk(mode_a, cmsf_pkg::ASYNC_FIFO);
      chk(mode_b, cmsf_pkg::ASYNC_FIFO);
      cfg(3'h3, 3'h4);
      chk(mode_a, cmsf_pkg::ASYNC_FIFO);
      suspended = 1'b1;
      pulse(7, 1, 0);
      pulse(WAKE + 10, 1, 1);
      wake_pulldown_en = 1'b1;
      pulse(WAKE + 10, 1, 0);
      wake_pulldown_en = 1'b0;
      suspended = 1'b0;
      pulse(WAKE + 10, 1, 0);
      $display("done: flush and wake");

      cmd(1'b0, 8'h01, 1'b0);
      chk(mode_a, cmsf_pkg::ASYNC_FIFO);
      enum_done = 1'b1;
      cmd(1'b1, 8'h40, 1'b0);
      // Channel B has moved no data here, so its pins keep their idle levels
      cmd(1'b0, 8'h40, 1'b1);
      chk(mode_a, cmsf_pkg::SYNC_FIFO);
      tick();
      chk({chan_b_avail, chb_override}, 2'b01);
      chk({chb_data_oe, chb_pullup_en, chb_tx_space_avail_n}, 3'b010);
      chk({chb_rx_data_avail_n, chb_strobe_in}, 2'b11);
      cmd(1'b1, 8'h01, 1'b0);
      pulse(7, 1, 0);
      for (int k = 0; k < 4; k++) begin
         cmd(1'b0, cmd_tab[k], 1'b1);
         chk(mode_a, mode_tab[k]);
         pulse(7, send_tab[k], 0);
      end
      chk(chan_b_avail, 1'b1);
      cmd(1'b1, 8'h04, 1'b1);
      chk(mode_b, cmsf_pkg::SYNC_BB);
      cmd(1'b0, 8'h33, 1'b0);
      chk(mode_a, cmsf_pkg::HOST_BUS);
      cmd(1'b0, 8'h00, 1'b1);
      chk(mode_a, cmsf_pkg::ASYNC_FIFO);
      $display("done: commands");

      do_rst();
      chk(mode_a, cmsf_pkg::ASYNC_SERIAL);
      cfg(3'h2, 3'h0);
      chk(mode_a, cmsf_pkg::ASYNC_FIFO);
      chk(mode_b, cmsf_pkg::ASYNC_SERIAL);
      cmd(1'b0, 8'h40, 1'b0);
      $display("done: sync fifo refused");

      // Fast serial and CPU FIFO only reachable from memory
      do_rst();
      cfg(3'h3, 3'h4);
      chk(mode_a, cmsf_pkg::FAST_SERIAL);
      chk(mode_b, cmsf_pkg::CPU_FIFO);
      pulse(7, 0, 0);
      $display("done: other base modes");
      give_verdict();
   end
endmodule // cmsf_top_tb_top
